// File: rtl/wwdt_pkg.sv
// Purpose: shared constants and types for the windowed watchdog timer
// Assumes: 32-bit classic Wishbone register bus, 10 MHz system clock
// Notes:   register offsets are byte addresses of aligned words
`default_nettype none
package wwdt_pkg;
    // oscillator rate and base timeout periods per prescaler mode
    localparam int unsigned OSC_HZ         = 32000;
    localparam int unsigned PERIOD_5BIT_US = 1000;
    localparam int unsigned PERIOD_7BIT_US = 4000;
    localparam int unsigned PRESC_DIV_5BIT = OSC_HZ * PERIOD_5BIT_US / 1000000;
    localparam int unsigned PRESC_DIV_7BIT = OSC_HZ * PERIOD_7BIT_US / 1000000;
    localparam int unsigned PRESC_W        = 7;
    localparam int unsigned POST_W         = 15;
    localparam int unsigned POST_SEL_W     = 4;
    localparam logic [6:0]  PRESC_LAST_5   = 7'(PRESC_DIV_5BIT - 1);
    localparam logic [6:0]  PRESC_LAST_7   = 7'(PRESC_DIV_7BIT - 1);

    // register byte offsets
    localparam logic [7:0]  ADR_CONFIG     = 8'h00;
    localparam logic [7:0]  ADR_RESET_CTL  = 8'h04;
    localparam logic [7:0]  ADR_STATUS     = 8'h08;

    // watchdog_config_word fields
    localparam int unsigned CFG_POST_LSB   = 0;
    localparam int unsigned CFG_PRESC_BIT  = 4;
    localparam int unsigned CFG_HWEN_BIT   = 5;
    localparam int unsigned CFG_WDIS_BIT   = 6;
    localparam logic [6:0]  CFG_RESET      = 7'h40;

    // reset_control_reg fields
    localparam int unsigned RC_IDLE_BIT    = 2;
    localparam int unsigned RC_SLEEP_BIT   = 3;
    localparam int unsigned RC_TOUT_BIT    = 4;
    localparam int unsigned RC_SWEN_BIT    = 5;

    // status register fields
    localparam int unsigned ST_POST_LSB    = 8;
    localparam int unsigned ST_PWR_LSB     = 24;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wwdt_wb_req_t;

    typedef enum logic [2:0] {
        WWDT_RUN   = 3'b001,
        WWDT_SLEEP = 3'b010,
        WWDT_IDLE  = 3'b100
    } wwdt_pwr_t;
endpackage
`default_nettype wire

// File: rtl/wwdt_top.sv
// Purpose: windowed watchdog timer clocked by the low-power rc oscillator
// Assumes: oscillator arrives as a pin and is sampled on clk_i; rst_i is the device reset
// Notes:   all state freezes while ce_i is low
//
// Notes on behaviour
// - watchdog counts oscillator edges; enabling it switches the oscillator on
// - prescaler divides by 32 or 128 per prescale_select
// - with a 32 kHz source base periods are 1 ms and 4 ms
// - four-bit postscale_select picks a ratio from 1:1 to 1:32768
// - reset, clock switch, power save, wake and clear zero all counters
// - enabled watchdog keeps counting in sleep and idle
// - timeout in sleep or idle wakes the core instead of resetting
// - sleep and idle status bits stay set until software clears them
// - hardware enable forces the watchdog on regardless of software enable
// - without hardware enable the watchdog runs only while software enable is set
// - every device reset clears software enable
// - with window enabled an early clear causes a watchdog reset
// - timeout flag stays set until software writes it clear
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire wwdt_wb_req_t wb_req_i,
    output logic              wb_ack_o,
    output logic [31:0]       wb_dat_o,
    input  wire logic         low_power_rc_osc_i,
    output logic              low_power_rc_osc_en_o,
    input  wire logic         watchdog_clear_instr_i,
    input  wire logic         power_save_instr_i,
    input  wire logic         power_save_idle_i,
    input  wire logic         clock_switch_done_i,
    input  wire logic         wake_event_i,
    output logic              watchdog_reset_o,
    output logic              watchdog_wake_o
);
    // postscaler terminal count for a ratio of 2**sel
    function automatic logic [POST_W-1:0] post_last_of(input logic [POST_SEL_W-1:0] sel);
        logic [POST_W:0] ratio;
        ratio = (POST_W+1)'(1) << sel;
        return POST_W'(ratio - (POST_W+1)'(1));
    endfunction

    logic [6:0]           cfg;
    logic                 sw_watchdog_enable;
    logic                 watchdog_timeout_flag;
    logic                 sleep_flag;
    logic                 idle_flag;
    logic [PRESC_W-1:0]   presc_cnt;
    logic [POST_W-1:0]    post_cnt;
    logic                 osc_meta;
    logic                 osc_sync;
    logic                 osc_prev;
    wwdt_pwr_t            pwr;
    wwdt_pwr_t            next_pwr;
    logic                 ack;
    logic [31:0]          rdata;

    // configuration fields
    wire [POST_SEL_W-1:0] postscale_select   = cfg[CFG_POST_LSB +: POST_SEL_W];
    wire                  prescale_select    = cfg[CFG_PRESC_BIT];
    wire                  hw_watchdog_enable = cfg[CFG_HWEN_BIT];
    wire                  window_disable     = cfg[CFG_WDIS_BIT];

    // enable and oscillator request
    wire wdt_enable = hw_watchdog_enable | sw_watchdog_enable;
    assign low_power_rc_osc_en_o = wdt_enable;

    // one counting edge per oscillator rising edge, taken after the synchroniser
    wire osc_tick = osc_sync & ~osc_prev;

    // prescaler and postscaler terminal detection
    wire [PRESC_W-1:0] presc_last = prescale_select ? PRESC_LAST_7 : PRESC_LAST_5;
    wire [POST_W-1:0]  post_last  = post_last_of(postscale_select);
    wire presc_wrap = osc_tick & (presc_cnt == presc_last);
    wire timeout    = wdt_enable & presc_wrap & (post_cnt == post_last);

    // window: elapsed oscillator edges against three quarters of the period
    wire [24:0] elapsed = prescale_select ? {3'h0, post_cnt, presc_cnt}
                                          : {5'h00, post_cnt, presc_cnt[4:0]};
    wire [24:0] total   = prescale_select ? {2'h0, 16'(post_last) + 16'h0001, 7'h00}
                                          : {4'h0, 16'(post_last) + 16'h0001, 5'h00};
    wire        early   = ({elapsed[22:0], 2'b00}) < (total + {total[23:0], 1'b0});

    // instruction decode; instructions only execute while the core runs
    wire running    = (pwr == WWDT_RUN);
    wire clr_instr  = running & watchdog_clear_instr_i;
    wire early_clr  = clr_instr & wdt_enable & ~window_disable & early;
    wire sleep_in   = running & power_save_instr_i;
    wire wake_ext   = ~running & wake_event_i;
    wire wake_wdt   = ~running & timeout;
    wire run_reset  = running & timeout;

    // bus decode; a write lands on the edge at which the master sees ack
    wire req        = wb_req_i.cyc & wb_req_i.stb;
    wire wr_low     = req & wb_req_i.we & ack & wb_req_i.sel[0];
    wire wr_cfg     = wr_low & (wb_req_i.adr == ADR_CONFIG);
    wire wr_rc      = wr_low & (wb_req_i.adr == ADR_RESET_CTL);
    wire [31:0] rc_word = {26'h0, sw_watchdog_enable, watchdog_timeout_flag, sleep_flag, idle_flag, 2'b00};
    wire [31:0] st_word = {5'h00, pwr, 1'b0, post_cnt, 1'b0, presc_cnt};
    wire [31:0] rd_mux  = (wb_req_i.adr == ADR_CONFIG)    ? {25'h0, cfg}
                        : (wb_req_i.adr == ADR_RESET_CTL) ? rc_word
                        : (wb_req_i.adr == ADR_STATUS)    ? st_word : 32'h0;
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // every clear source; a config load counts too, so a smaller ratio cannot strand the count
    wire cnt_clear  = clock_switch_done_i | sleep_in | wake_ext | wake_wdt | clr_instr
                    | timeout | ~wdt_enable | wr_cfg;

    // power state sequencing
    always_comb
    begin
        next_pwr = pwr;
        case (pwr)
            WWDT_RUN:   if (sleep_in) next_pwr = power_save_idle_i ? WWDT_IDLE : WWDT_SLEEP;
            WWDT_SLEEP: if (wake_wdt | wake_ext) next_pwr = WWDT_RUN;
            WWDT_IDLE:  if (wake_wdt | wake_ext) next_pwr = WWDT_RUN;
            default:    next_pwr = WWDT_RUN;
        endcase
    end

    // oscillator synchroniser; the first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            osc_meta <= low_power_rc_osc_i;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // prescaler and postscaler; any clear source wins over counting
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            presc_cnt <= '0;
            post_cnt  <= '0;
        end
        else if (ce_i)
        begin
            if (cnt_clear)
            begin
                presc_cnt <= '0;
                post_cnt  <= '0;
            end
            else if (presc_wrap)
            begin
                presc_cnt <= '0;
                post_cnt  <= post_cnt + POST_W'(1);
            end
            else if (osc_tick)
                presc_cnt <= presc_cnt + PRESC_W'(1);
        end
    end

    // power state, event pulses and bus handshake
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pwr              <= WWDT_RUN;
            watchdog_reset_o <= 1'b0;
            watchdog_wake_o  <= 1'b0;
            ack              <= 1'b0;
            rdata            <= 32'h0;
        end
        else if (ce_i)
        begin
            pwr              <= next_pwr;
            watchdog_reset_o <= run_reset | early_clr;
            watchdog_wake_o  <= wake_wdt;
            ack              <= req & ~ack;
            rdata            <= rd_mux;
        end
    end

    // configuration word; it stands for the fuse bits, so software may load it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg <= CFG_RESET;
        else if (ce_i && wr_cfg)
            cfg <= wb_req_i.dat[6:0];
    end

    // reset-control bits; a hardware set in the same cycle as a write wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sw_watchdog_enable    <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            sleep_flag            <= 1'b0;
            idle_flag             <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_rc)
                sw_watchdog_enable <= wb_req_i.dat[RC_SWEN_BIT];
            watchdog_timeout_flag <= timeout | early_clr
                                   | (wr_rc ? wb_req_i.dat[RC_TOUT_BIT] : watchdog_timeout_flag);
            sleep_flag <= (sleep_in & ~power_save_idle_i)
                        | (wr_rc ? wb_req_i.dat[RC_SLEEP_BIT] : sleep_flag);
            idle_flag  <= (sleep_in & power_save_idle_i)
                        | (wr_rc ? wb_req_i.dat[RC_IDLE_BIT] : idle_flag);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_osc_on_hw;
        hw_watchdog_enable |-> low_power_rc_osc_en_o;
    endproperty
    a_osc_on_hw: assert property (p_osc_on_hw) else $error("oscillator off while hardware enable set");

    property p_presc_wrap32;
        ce_i && !cnt_clear && osc_tick && !prescale_select && presc_cnt == 7'h1F
            |=> presc_cnt == 7'h00 && post_cnt == $past(post_cnt) + 15'h0001;
    endproperty
    a_presc_wrap32: assert property (p_presc_wrap32) else $error("prescaler did not wrap at 32");

    property p_presc_wrap128;
        ce_i && !cnt_clear && osc_tick && prescale_select && presc_cnt == 7'h7F
            |=> presc_cnt == 7'h00 && post_cnt == $past(post_cnt) + 15'h0001;
    endproperty
    a_presc_wrap128: assert property (p_presc_wrap128) else $error("prescaler did not wrap at 128");

    property p_post_range;
        post_cnt <= post_last;
    endproperty
    a_post_range: assert property (p_post_range) else $error("postscaler beyond selected ratio");

    property p_clear_zeroes;
        ce_i && clr_instr && !early_clr |=> presc_cnt == 7'h00 && post_cnt == 15'h0000 && !watchdog_reset_o;
    endproperty
    a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear did not zero counters");

    property p_sleep_counts;
        ce_i && !running && wdt_enable && osc_tick && !presc_wrap && !cnt_clear
            |=> presc_cnt == $past(presc_cnt) + 7'h01;
    endproperty
    a_sleep_counts: assert property (p_sleep_counts) else $error("watchdog stalled in power save");

    property p_wake_not_reset;
        ce_i && wake_wdt |=> watchdog_wake_o && running && !watchdog_reset_o;
    endproperty
    a_wake_not_reset: assert property (p_wake_not_reset) else $error("timeout in power save did not wake");

    property p_sleep_sticky;
        sleep_flag && !wr_rc |=> sleep_flag;
    endproperty
    a_sleep_sticky: assert property (p_sleep_sticky) else $error("sleep bit lost without a write");

    property p_off_holds;
        ce_i && !wdt_enable |=> presc_cnt == 7'h00 && post_cnt == 15'h0000 ##1 !watchdog_reset_o;
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("disabled watchdog kept counting");

    property p_rst_swen;
        disable iff (1'b0) rst_i |=> !sw_watchdog_enable;
    endproperty
    a_rst_swen: assert property (p_rst_swen) else $error("software enable survived reset");

    property p_early_reset;
        ce_i && early_clr |=> watchdog_reset_o && watchdog_timeout_flag;
    endproperty
    a_early_reset: assert property (p_early_reset) else $error("early clear gave no reset");

    property p_flag_sticky;
        watchdog_timeout_flag && !wr_rc |=> watchdog_timeout_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("timeout flag dropped on its own");

    property p_run_timeout;
        ce_i && run_reset |=> watchdog_reset_o && watchdog_timeout_flag && post_cnt == 15'h0000;
    endproperty
    a_run_timeout: assert property (p_run_timeout) else $error("running timeout gave no reset");

    property p_ce_freeze;
        !ce_i |=> $stable(presc_cnt) && $stable(post_cnt) && $stable(pwr);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");

    c_run_timeout: cover property (ce_i && run_reset);
    c_ext_wake:    cover property (ce_i && wake_ext);
    c_wake:        cover property (ce_i && wake_wdt);
    c_early_clear: cover property (ce_i && early_clr);
    c_good_clear:  cover property (ce_i && clr_instr && wdt_enable && !early);
endmodule // wwdt_top
`default_nettype wire

// File: verification/wwdt_tb.sv
// Purpose: self-checking bench for the windowed watchdog timer
// Assumes: oscillator pin driven by the bench, eight clocks per oscillator period
// Notes:   a fast oscillator stands in for the slow rc source to keep runs short
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wwdt_pkg::*;
    logic         clk_i, rst_i, ce_i, osc, clr, psv, idl, csw, wak;
    wwdt_wb_req_t req;
    logic         ack, rst_o, wake_o, osc_en;
    logic [31:0]  rdat, rd;
    int           err_total, num_checks, i, k, len;
    int           n_rst = 0;
    int           n_wake = 0;
    int           exp_rst = 0;
    int           cfgs [3] = '{32'h60, 32'h62, 32'h71};
    // register walk rows: write flag, offset, write data, expected read
    logic [31:0]  rows [10][4] = '{
        '{32'h0, ADR_CONFIG, 32'h0, CFG_RESET}, '{32'h0, ADR_RESET_CTL, 32'h0, 32'h0},
        '{32'h1, 8'h0C, 32'hFF, 32'h0}, '{32'h0, 8'h0C, 32'h0, 32'h0},
        '{32'h1, ADR_CONFIG, 32'hFFFFFF15, 32'h0}, '{32'h0, ADR_CONFIG, 32'h0, 32'h15},
        '{32'h1, ADR_CONFIG, 32'h40, 32'h0}, '{32'h0, ADR_STATUS, 32'h0, 32'h01000000},
        '{32'h1, ADR_RESET_CTL, 32'h20, 32'h0}, '{32'h0, ADR_RESET_CTL, 32'h0, 32'h20}};

    wwdt_top u_wwdt_top (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat),
        .low_power_rc_osc_i(osc), .low_power_rc_osc_en_o(osc_en), .watchdog_clear_instr_i(clr),
        .power_save_instr_i(psv), .power_save_idle_i(idl), .clock_switch_done_i(csw),
        .wake_event_i(wak), .watchdog_reset_o(rst_o), .watchdog_wake_o(wake_o));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // tally output pulses; a lost or doubled pulse shows in the totals
    always @(posedge clk_i)
    begin
        if (rst_o === 1'b1)
            n_rst <= n_rst + 1;
        if (wake_o === 1'b1)
            n_wake <= n_wake + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one classic cycle; a missing ack ends the run instead of hanging
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge clk_i);
        if (ack !== 1'b1)
        begin
            err_total++;
            results();
        end
        else
        begin
            rd = rdat;
            req <= '0;
            @(posedge clk_i); // a write lands on the ack edge; look only once it has settled
        end
    endtask

    // bits: clear, power save, clock switch; outputs land the cycle after
    task automatic pulse(input logic [2:0] k3);
        @(posedge clk_i);
        {clr, psv, csw} <= k3;
        @(posedge clk_i);
        {clr, psv, csw} <= 3'h0;
        repeat (3) @(posedge clk_i);
    endtask

    // each edge leaves room for the two-flop sync and the edge detect
    task automatic edges(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            osc <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    initial
    begin
        {rst_i, ce_i, osc, clr, psv, idl, csw, wak} = 8'hC0;
        req = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        check(osc_en, 1'b0);
        for (i = 0; i < 10; i++)
        begin
            wb(rows[i][0][0], rows[i][1][7:0], rows[i][2]);
            if (rows[i][0][0] == 1'b0)
                check(rd, rows[i][3]);
        end
        check(osc_en, 1'b1);
        wb(1'b1, ADR_RESET_CTL, 32'h0);
        check(osc_en, 1'b0);
        wb(1'b1, ADR_CONFIG, 32'h60);
        check(osc_en, 1'b1);
        $display("test registers done");
        // timeout length per prescaler mode and postscale ratio
        for (k = 0; k < 3; k++)
        begin
            len = (k == 2 ? PRESC_DIV_7BIT : PRESC_DIV_5BIT) << (cfgs[k] & 15);
            wb(1'b1, ADR_CONFIG, cfgs[k]);
            pulse(3'h4);
            edges(len - 1);
            check(n_rst, exp_rst);
            edges(1);
            exp_rst++;
            check(n_rst, exp_rst);
            wb(1'b0, ADR_RESET_CTL, 32'h0);
            wb(1'b0, ADR_RESET_CTL, 32'h0);
            check(rd[RC_TOUT_BIT], 1'b1);
            wb(1'b1, ADR_RESET_CTL, 32'h0);
        end
        $display("test timeout done");
        // clear and clock switch restart the count mid-period
        wb(1'b1, ADR_CONFIG, 32'h60);
        for (k = 0; k < 2; k++)
        begin
            edges(20);
            pulse(k == 0 ? 3'h4 : 3'h1);
            edges(PRESC_DIV_5BIT - 1);
            check(n_rst, exp_rst);
            edges(1);
            exp_rst++;
            check(n_rst, exp_rst);
            wb(1'b1, ADR_RESET_CTL, 32'h0);
        end
        $display("test restart done");
        // sleep then idle: timeout wakes instead of resetting
        for (k = 0; k < 2; k++)
        begin
            edges(20);
            @(posedge clk_i);
            idl <= k[0];
            pulse(3'h2);
            wb(1'b0, ADR_STATUS, 32'h0);
            check(rd[26:24], k ? 3'b100 : 3'b010);
            edges(PRESC_DIV_5BIT);
            check(n_wake, k + 1);
            check(n_rst, exp_rst);
            wb(1'b0, ADR_RESET_CTL, 32'h0);
            check(rd, k ? 32'h14 : 32'h18);
            wb(1'b0, ADR_STATUS, 32'h0);
            check(rd[26:24], 3'b001);
            wb(1'b1, ADR_RESET_CTL, 32'h0);
        end
        // clear is refused in power save; an outside wake restarts the count with no wake pulse
        pulse(3'h2);
        edges(10);
        pulse(3'h4);
        wb(1'b0, ADR_STATUS, 32'h0);
        check(rd, 32'h0400000A);
        @(posedge clk_i);
        wak <= 1'b1;
        @(posedge clk_i);
        wak <= 1'b0;
        wb(1'b0, ADR_STATUS, 32'h0);
        check(rd, 32'h01000000);
        check(n_wake, 32'h2);
        check(n_rst, exp_rst);
        wb(1'b1, ADR_RESET_CTL, 32'h0);
        $display("test power save done");
        // early clear resets, clear in the last quarter does not
        for (k = 0; k < 2; k++)
        begin
            wb(1'b1, ADR_CONFIG, 32'h60);
            pulse(3'h4);
            wb(1'b1, ADR_CONFIG, 32'h20);
            edges(k == 0 ? 23 : 24);
            pulse(3'h4);
            exp_rst += (k == 0);
            check(n_rst, exp_rst);
            wb(1'b0, ADR_RESET_CTL, 32'h0);
            check(rd[RC_TOUT_BIT], k == 0);
            wb(1'b1, ADR_RESET_CTL, 32'h0);
        end
        $display("test window done");
        // a low clock enable freezes the count, which resumes from where it stood
        wb(1'b1, ADR_CONFIG, 32'h60);
        pulse(3'h4);
        @(posedge clk_i);
        ce_i <= 1'b0;
        edges(40);
        @(posedge clk_i);
        ce_i <= 1'b1;
        check(n_rst, exp_rst);
        edges(PRESC_DIV_5BIT);
        exp_rst++;
        check(n_rst, exp_rst);
        $display("test clock enable done");
        wb(1'b1, ADR_RESET_CTL, 32'h20);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, ADR_RESET_CTL, 32'h0);
        check(rd, 32'h0);
        check(osc_en, 1'b0);
        $display("test reset done");
        results();
    end
endmodule // testbench
`default_nettype wire
